// ==== rtl/pcr_consts.svh ====
/*
  Constants for the synthesizer configuration bank, registers four to nine and eleven:
  control selector codes, field positions and widths.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

`define PCR_SEL_R0 4'h0
`define PCR_SEL_R4 4'h4
`define PCR_SEL_R5 4'h5
`define PCR_SEL_R6 4'h6
`define PCR_SEL_R7 4'h7
`define PCR_SEL_R8 4'h8
`define PCR_SEL_R9 4'h9
`define PCR_SEL_R11 4'hB
`define PCR_SEL_LO 3
`define PCR_SEL_HI 0

`define PCR_AUXMOD_HI 27
`define PCR_AUXMOD_LO 4
`define PCR_LDPIN_HI 31
`define PCR_LDPIN_LO 30
`define PCR_CP_HI 28
`define PCR_CP_LO 25
`define PCR_XBIT 24
`define PCR_PRESC 23
`define PCR_RHALF 22
`define PCR_RDBL 21
`define PCR_RCNT_HI 20
`define PCR_RCNT_LO 16
`define PCR_CLK1_HI 15
`define PCR_CLK1_LO 4

`define PCR_BLEED_HI 31
`define PCR_BLEED_LO 24
`define PCR_BLPOL 23
`define PCR_BLEN 22
`define PCR_INTMODE 20
`define PCR_ABW 19
`define PCR_LOSTREF 18
`define PCR_SDRST_SKIP 17
`define PCR_CPTRI_PD 16
`define PCR_LDPREC_HI 9
`define PCR_LDPREC_LO 8
`define PCR_PDPOL 7
`define PCR_PWRDN 6
`define PCR_CPTRI 5
`define PCR_CNTRST 4

`define PCR_LDCLK 20
`define PCR_CLKMODE_HI 19
`define PCR_CLKMODE_LO 18
`define PCR_CLK2_HI 17
`define PCR_CLK2_LO 6
`define PCR_LDCNT_HI 27
`define PCR_LDCNT_LO 24

`define PCR_LDBIAS_HI 31
`define PCR_LDBIAS_LO 30
`define PCR_REGON 31

`define PCR_LD_NORMAL 2'h1
`define PCR_LD_LOW 2'h2
`define PCR_LD_HIGH 2'h3
`define PCR_CLKMODE_RESYNC 2'h2
`define PCR_SLOW_CHECK 5'h1F

`endif

// ==== rtl/pcr_pkg.sv ====
/*
  Types for the synthesizer configuration bank.
  Stands alone; the constants header is not included here.
*/
package pcr_pkg;
  typedef enum logic [1:0] {
    PCR_LD_TRI = 2'b00,
    PCR_LD_NORM = 2'b01,
    PCR_LD_FLOW = 2'b10,
    PCR_LD_FHIGH = 2'b11
  } pcr_ldmode_t;

  typedef enum logic [1:0] {
    PCR_CMP_IDLE = 2'b00,
    PCR_CMP_COUNT = 2'b01,
    PCR_CMP_LOCKED = 2'b10
  } pcr_lkst_t;
endpackage

// ==== rtl/pcr_lock_detect.sv ====
/*
  Digital lock detector: counts consecutive in-window phase comparisons.
  Assumes cmp_strobe and in_window come from the same clock domain.
*/
`timescale 1ns/100ps
`include "pcr_consts.svh"

module pcr_lock_detect #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmp_strobe,
  input wire logic in_window,
  input wire logic ref_present,
  input wire logic lost_ref_en,
  input wire logic every_cycle,
  input wire logic hold,
  input wire logic [CNT_W-1:0] count_init,
  output logic locked
);
  import pcr_pkg::*;

  typedef struct packed {
    pcr_lkst_t st;
    logic [CNT_W-1:0] cnt;
    logic [4:0] pre;
    logic lk;
  } pcr_ld_state_t;

  pcr_ld_state_t s_q, s_d;
  logic check;

  always_comb begin
    s_d = s_q;
    // Slow mode samples only every 32nd comparison
    check = cmp_strobe && (every_cycle || s_q.pre == `PCR_SLOW_CHECK);
    if (cmp_strobe) begin
      s_d.pre = s_q.pre + 5'h1;
    end
    if (hold) begin
      s_d.st = PCR_CMP_IDLE;
      s_d.lk = 1'b0;
    end else if (lost_ref_en && !ref_present && s_q.lk) begin
      s_d.st = PCR_CMP_IDLE;
      s_d.lk = 1'b0;
    end else if (check) begin
      case (s_q.st)
        PCR_CMP_IDLE: begin
          if (in_window) begin
            s_d.st = PCR_CMP_COUNT;
            s_d.cnt = count_init;
          end
        end
        PCR_CMP_COUNT: begin
          if (!in_window) begin
            s_d.st = PCR_CMP_IDLE;
          end else if (s_q.cnt == '0) begin
            s_d.st = PCR_CMP_LOCKED;
            s_d.lk = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt - 1'b1;
          end
        end
        default: begin
          if (!in_window) begin
            s_d.st = PCR_CMP_IDLE;
            s_d.lk = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign locked = s_q.lk;
endmodule

// ==== rtl/pcr_config_regs.sv ====
/*
  Configuration bank for registers four to nine and eleven of a fractional-N
  synthesizer, with the register 0 apply event and lock indication pin.
  Assumes a serial front end delivers complete 32-bit words with a one-cycle
  load strobe; the low four bits select the register. Phase detector events
  arrive as pin-level signals and are synchronised here.
*/
`timescale 1ns/100ps
`include "pcr_consts.svh"

module pcr_config_regs #(
  parameter int AUXMOD_W = 24,
  parameter int LDCNT_W = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load_strobe,
  input wire logic [31:0] load_word,
  input wire logic ref_present_pin,
  input wire logic cmp_strobe_pin,
  input wire logic in_window_pin,
  input wire logic fixed_modulus_mode,
  output logic [AUXMOD_W-1:0] aux_modulus,
  output logic [3:0] charge_pump_code,
  output logic extra_modulus_bit_disable,
  output logic prescaler_89,
  output logic reference_halver,
  output logic reference_doubler,
  output logic [4:0] ref_counter_value,
  output logic [11:0] resync_div1,
  output logic [7:0] bleed_code,
  output logic bleed_negative,
  output logic bleed_enable,
  output logic sigma_delta_modulator_off,
  output logic antibacklash_width,
  output logic charge_pump_tristate,
  output logic phase_detector_positive,
  output logic [1:0] lock_window_precision,
  output logic [1:0] lock_window_bias,
  output logic power_down,
  output logic divider_regulator_on,
  output logic counters_reset,
  output logic resync_enable,
  output logic [11:0] resync_div2,
  output logic [1:0] resync_mode,
  output logic [LDCNT_W-1:0] lock_counter_init,
  output logic lock_check_rate_select,
  output logic apply_pulse,
  output logic fraction_zero_pulse,
  output logic lock_indicator_pin_o,
  output logic lock_indicator_pin_oe
);
  import pcr_pkg::*;

  typedef struct packed {
    logic [31:0] r4;
    logic [31:0] r5;
    logic [31:0] r6;
    logic [31:0] r7;
    logic [31:0] r9;
    logic [31:0] r11;
    logic [1:0] ref_sync;
    logic [1:0] cmp_sync;
    logic [1:0] win_sync;
    logic cmp_prev;
    logic apply;
    logic fzero;
    logic ld_o;
    logic ld_oe;
    logic cptri;
    logic bleed_neg;
    logic resync_en;
    logic [AUXMOD_W-1:0] auxmod_eff;
  } pcr_cfg_state_t;

  pcr_cfg_state_t s_q, s_d;
  logic [3:0] sel;
  logic locked;
  logic cmp_edge;
  pcr_ldmode_t ld_mode;

  assign sel = load_word[`PCR_SEL_LO:`PCR_SEL_HI];
  assign cmp_edge = s_q.cmp_sync[1] && !s_q.cmp_prev;
  assign ld_mode = pcr_ldmode_t'(s_q.r5[`PCR_LDPIN_HI:`PCR_LDPIN_LO]);

  pcr_lock_detect #(
    .CNT_W(LDCNT_W)
  ) u_lock (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cmp_strobe(cmp_edge),
    .in_window(s_q.win_sync[1]),
    .ref_present(s_q.ref_sync[1]),
    .lost_ref_en(s_q.r6[`PCR_LOSTREF]),
    .every_cycle(s_q.r7[`PCR_LDCLK]),
    .hold(s_q.r6[`PCR_PWRDN] || s_q.r6[`PCR_CNTRST]),
    .count_init(s_q.r7[`PCR_LDCNT_HI:`PCR_LDCNT_LO]),
    .locked(locked)
  );

  always_comb begin
    s_d = s_q;
    s_d.ref_sync = {s_q.ref_sync[0], ref_present_pin};
    s_d.cmp_sync = {s_q.cmp_sync[0], cmp_strobe_pin};
    s_d.win_sync = {s_q.win_sync[0], in_window_pin};
    s_d.cmp_prev = s_q.cmp_sync[1];
    s_d.apply = 1'b0;
    s_d.fzero = 1'b0;
    // Register 8 carries no live field; its write is accepted and dropped
    if (load_strobe) begin
      if (sel == `PCR_SEL_R0) begin
        s_d.apply = 1'b1;
        s_d.fzero = !s_q.r6[`PCR_SDRST_SKIP];
      end else if (sel == `PCR_SEL_R4) begin
        s_d.r4 = load_word;
      end else if (sel == `PCR_SEL_R5) begin
        s_d.r5 = load_word;
      end else if (sel == `PCR_SEL_R6) begin
        s_d.r6 = load_word;
      end else if (sel == `PCR_SEL_R7) begin
        s_d.r7 = load_word;
      end else if (sel == `PCR_SEL_R9) begin
        s_d.r9 = load_word;
      end else if (sel == `PCR_SEL_R11) begin
        s_d.r11 = load_word;
      end
    end
    // Fixed modulus ignores aux modulus; presented as zero to the modulator
    // Taken from the next register value so it lands with the load
    if (fixed_modulus_mode) begin
      s_d.auxmod_eff = '0;
    end else begin
      s_d.auxmod_eff = s_d.r4[`PCR_AUXMOD_HI:`PCR_AUXMOD_LO];
    end
    // Decoded outputs other than the lock pin get flops of their own, fed from next state to keep load timing
    s_d.cptri = s_d.r6[`PCR_CPTRI_PD] | s_d.r6[`PCR_CPTRI];
    s_d.bleed_neg = !s_d.r6[`PCR_BLPOL];
    s_d.resync_en = (s_d.r7[`PCR_CLKMODE_HI:`PCR_CLKMODE_LO] == `PCR_CLKMODE_RESYNC);
    // Pin released during power-down so it does not fight the board
    if (s_q.r6[`PCR_PWRDN]) begin
      s_d.ld_oe = 1'b0;
      s_d.ld_o = 1'b0;
    end else begin
      case (ld_mode)
        PCR_LD_TRI: begin
          s_d.ld_oe = 1'b0;
          s_d.ld_o = 1'b0;
        end
        PCR_LD_NORM: begin
          s_d.ld_oe = 1'b1;
          s_d.ld_o = locked;
        end
        PCR_LD_FLOW: begin
          s_d.ld_oe = 1'b1;
          s_d.ld_o = 1'b0;
        end
        default: begin
          s_d.ld_oe = 1'b1;
          s_d.ld_o = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Field outputs come from the register flops or from their own decoded flops
  assign aux_modulus = s_q.auxmod_eff;
  assign charge_pump_code = s_q.r5[`PCR_CP_HI:`PCR_CP_LO];
  assign extra_modulus_bit_disable = s_q.r5[`PCR_XBIT];
  assign prescaler_89 = s_q.r5[`PCR_PRESC];
  assign reference_halver = s_q.r5[`PCR_RHALF];
  assign reference_doubler = s_q.r5[`PCR_RDBL];
  assign ref_counter_value = s_q.r5[`PCR_RCNT_HI:`PCR_RCNT_LO];
  assign resync_div1 = s_q.r5[`PCR_CLK1_HI:`PCR_CLK1_LO];
  assign bleed_code = s_q.r6[`PCR_BLEED_HI:`PCR_BLEED_LO];
  assign bleed_negative = s_q.bleed_neg;
  assign bleed_enable = s_q.r6[`PCR_BLEN];
  assign sigma_delta_modulator_off = s_q.r6[`PCR_INTMODE];
  assign antibacklash_width = s_q.r6[`PCR_ABW];
  assign phase_detector_positive = s_q.r6[`PCR_PDPOL];
  assign lock_window_precision = s_q.r6[`PCR_LDPREC_HI:`PCR_LDPREC_LO];
  assign lock_window_bias = s_q.r9[`PCR_LDBIAS_HI:`PCR_LDBIAS_LO];
  assign power_down = s_q.r6[`PCR_PWRDN];
  assign divider_regulator_on = s_q.r11[`PCR_REGON];
  assign counters_reset = s_q.r6[`PCR_CNTRST];
  assign resync_mode = s_q.r7[`PCR_CLKMODE_HI:`PCR_CLKMODE_LO];
  assign resync_enable = s_q.resync_en;
  assign resync_div2 = s_q.r7[`PCR_CLK2_HI:`PCR_CLK2_LO];
  assign lock_counter_init = s_q.r7[`PCR_LDCNT_HI:`PCR_LDCNT_LO];
  assign lock_check_rate_select = s_q.r7[`PCR_LDCLK];
  assign apply_pulse = s_q.apply;
  assign fraction_zero_pulse = s_q.fzero;
  assign lock_indicator_pin_o = s_q.ld_o;
  assign lock_indicator_pin_oe = s_q.ld_oe;
  assign charge_pump_tristate = s_q.cptri;
endmodule

// ==== verif/pcr_config_regs_checker.sv ====
/*
  Concurrent checks on the configuration bank ports.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/100ps
module pcr_config_regs_checker #(
  parameter int AUXMOD_W = 24,
  parameter int LDCNT_W = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load_strobe,
  input wire logic [31:0] load_word,
  input wire logic fixed_modulus_mode,
  input wire logic [AUXMOD_W-1:0] aux_modulus,
  input wire logic [3:0] charge_pump_code,
  input wire logic [4:0] ref_counter_value,
  input wire logic [11:0] resync_div1,
  input wire logic sigma_delta_modulator_off,
  input wire logic antibacklash_width,
  input wire logic charge_pump_tristate,
  input wire logic power_down,
  input wire logic counters_reset,
  input wire logic resync_enable,
  input wire logic [1:0] resync_mode,
  input wire logic apply_pulse,
  input wire logic fraction_zero_pulse,
  input wire logic lock_indicator_pin_oe
);
  logic w0, w5, w6, w7;
  assign w0 = load_strobe && load_word[3:0] == 4'h0;
  assign w5 = load_strobe && load_word[3:0] == 4'h5;
  assign w6 = load_strobe && load_word[3:0] == 4'h6;
  assign w7 = load_strobe && load_word[3:0] == 4'h7;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_aux_fixed_zero: assert property (fixed_modulus_mode |=> aux_modulus == '0)
    else $error("aux modulus not zero in fixed mode");
  a_r5_field_load: assert property (w5 |=> {charge_pump_code, ref_counter_value, resync_div1} ==
    {$past(load_word[28:25]), $past(load_word[20:4])})
    else $error("register five fields wrong");
  a_apply_only_r0: assert property (1'b1 |-> apply_pulse == $past(w0))
    else $error("apply pulse not tied to register zero load");
  a_frac_zero_with: assert property (fraction_zero_pulse |-> apply_pulse)
    else $error("fraction zero pulse without apply");
  a_int_mode_load: assert property (w6 |=> {sigma_delta_modulator_off, antibacklash_width} ==
    $past(load_word[20:19]))
    else $error("modulator off or backlash width wrong");
  a_pump_tristate: assert property (w6 |=> charge_pump_tristate == ($past(load_word[16]) || $past(load_word[5])))
    else $error("pump three-state wrong");
  a_power_counter: assert property (w6 |=> power_down == $past(load_word[6]) &&
    counters_reset == $past(load_word[4]))
    else $error("power down or counter reset wrong");
  a_pin_off_pd: assert property (power_down |=> !lock_indicator_pin_oe)
    else $error("lock pin driven in power down");
  a_resync_mode: assert property (w7 |=> resync_mode == $past(load_word[19:18]) &&
    resync_enable == ($past(load_word[19:18]) == 2'h2))
    else $error("resync mode or enable wrong");
endmodule
bind pcr_config_regs pcr_config_regs_checker #(.AUXMOD_W(AUXMOD_W), .LDCNT_W(LDCNT_W)) pcr_config_regs_checker_i (.*);

// ==== verif/pcr_host_model.sv ====
/*
  Host controller: hands whole 32-bit words to the bank.
  Assumes calls to send come from one process only.
*/
`timescale 1ns/100ps
module pcr_host_model (
  input wire logic sys_clk,
  output logic load_strobe,
  output logic [31:0] load_word
);
  initial begin
    load_strobe = 1'b0;
    load_word = 32'h0;
  end
  // Word is released as its inverse so stale data cannot pass
  task automatic send(input logic [31:0] w);
    @(negedge sys_clk);
    load_strobe = 1'b1;
    load_word = w;
    @(negedge sys_clk);
    load_strobe = 1'b0;
    load_word = ~w;
  endtask
endmodule

// ==== verif/pcr_config_regs_tb_top.sv ====
/*
  Self-checking bench for the configuration bank.
  Assumes the host model and bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module pcr_config_regs_tb_top;
  localparam logic [31:0] W5 = 32'h55D5_ABC5;
  localparam logic [31:0] W6 = 32'h5ADC_02A6;
  localparam logic [31:0] W7 = 32'h0018_48C7;
  logic sys_clk, reset_n, ref_present_pin, cmp_strobe_pin;
  logic in_window_pin, fixed_modulus_mode, load_strobe, extra_modulus_bit_disable, prescaler_89;
  logic reference_halver, reference_doubler, bleed_negative, bleed_enable, sigma_delta_modulator_off;
  logic antibacklash_width, charge_pump_tristate, phase_detector_positive, power_down, divider_regulator_on;
  logic counters_reset, resync_enable, lock_check_rate_select, apply_pulse, fraction_zero_pulse;
  logic lock_indicator_pin_o, lock_indicator_pin_oe;
  logic [31:0] load_word;
  logic [23:0] aux_modulus;
  logic [11:0] resync_div1, resync_div2;
  logic [7:0] bleed_code;
  logic [4:0] ref_counter_value;
  logic [3:0] charge_pump_code, lock_counter_init;
  logic [1:0] lock_window_precision, lock_window_bias, resync_mode;
  int miscompares = 0, compares = 0;
  always #5 sys_clk = ~sys_clk;
  pcr_host_model pcr_host_model_i (.*);
  pcr_config_regs pcr_config_regs_i (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_r4;
    pcr_host_model_i.send(32'h0ABC_DEF4);
    chk(aux_modulus, 24'hABCDEF);
    fixed_modulus_mode = 1'b1;
    @(negedge sys_clk);
    chk(aux_modulus, 0);
    fixed_modulus_mode = 1'b0;
    $display("test r4 done");
  endtask
  task automatic t_r5;
    for (int m = 0; m < 4; m++) begin
      pcr_host_model_i.send({m[1:0], W5[29:0]});
      repeat (2) @(negedge sys_clk);
      chk({lock_indicator_pin_oe, lock_indicator_pin_o}, {m != 0, m == 3});
    end
    chk({charge_pump_code, extra_modulus_bit_disable, prescaler_89, reference_halver, reference_doubler,
      ref_counter_value, resync_div1}, W5[28:4]);
    $display("test r5 done");
  endtask
  task automatic t_r6;
    pcr_host_model_i.send(W6 | 32'h50);
    @(negedge sys_clk);
    chk({power_down, counters_reset, lock_indicator_pin_oe, charge_pump_code}, 7'h6A);
    pcr_host_model_i.send(W6);
    chk(apply_pulse, 0);
    chk({bleed_code, bleed_negative, bleed_enable, sigma_delta_modulator_off, antibacklash_width,
      charge_pump_tristate, phase_detector_positive, lock_window_precision, power_down, counters_reset},
      {W6[31:24], !W6[23], W6[22], W6[20:19], W6[16] | W6[5], W6[7], W6[9:8], W6[6], W6[4]});
    pcr_host_model_i.send(32'hC000_0009);
    pcr_host_model_i.send(32'h8000_000B);
    pcr_host_model_i.send(32'h8);
    chk({lock_window_bias, divider_regulator_on, apply_pulse, bleed_code}, {4'hE, W6[31:24]});
    pcr_host_model_i.send(32'h0);
    chk({apply_pulse, fraction_zero_pulse}, 2'h3);
    @(negedge sys_clk);
    chk({apply_pulse, fraction_zero_pulse}, 2'h0);
    pcr_host_model_i.send(W6 | 32'h2_0000);
    pcr_host_model_i.send(32'h0);
    chk({apply_pulse, fraction_zero_pulse}, 2'h2);
    $display("test r6 done");
  endtask
  task automatic t_lock;
    int i;
    pcr_host_model_i.send(W7);
    chk({lock_check_rate_select, resync_mode, resync_enable, resync_div2, lock_counter_init},
      {W7[20], W7[19:18], 1'b1, W7[17:6], W7[27:24]});
    pcr_host_model_i.send(W5);
    ref_present_pin = 1'b1;
    in_window_pin = 1'b1;
    for (i = 0; i < 40 && lock_indicator_pin_o !== 1'b1; i++) begin
      cmp_strobe_pin = ~cmp_strobe_pin;
      repeat (2) @(negedge sys_clk);
    end
    // A timeout counts as a failed lock and skips the loss check
    if (i == 40) begin
      chk(lock_indicator_pin_o, 1);
    end else begin
      chk(i <= 16, 1);
      ref_present_pin = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk(lock_indicator_pin_o, 0);
    end
    $display("test lock done");
  endtask
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    ref_present_pin = 1'b0;
    cmp_strobe_pin = 1'b0;
    in_window_pin = 1'b0;
    fixed_modulus_mode = 1'b0;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    chk({apply_pulse, lock_indicator_pin_oe, power_down, aux_modulus}, 0);
    $display("test reset done");
    t_r4();
    t_r5();
    t_r6();
    t_lock();
    tally_and_finish();
  end
endmodule
